// ==== rtl/rtp_defs.svh ====
// Constants of the trim, power and alarm control block.
// Assumes a 100 MHz register clock and a free-running timebase.
`ifndef RTP_DEFS_SVH
`define RTP_DEFS_SVH
`define RTP_CLK_MHZ 100
`define RTP_NV_MS 20
`define RTP_NV_CYC (`RTP_NV_MS * 1000 * `RTP_CLK_MHZ)
`define RTP_PULSE_NS 30517
`define RTP_PULSE_CYC ((`RTP_PULSE_NS * `RTP_CLK_MHZ + 999) / 1000)
`define RTP_DEV_ADDR 7'h6f
`define RTP_OFF_SR 8'h3f
`define RTP_OFF_INT 8'h11
`define RTP_OFF_ATR 8'h12
`define RTP_OFF_DTR 8'h13
`define RTP_OFF_PWR 8'h14
`define RTP_OFF_ALM_TOP 8'h0f
`define RTP_OFF_ALM1 4'h8
`define RTP_DWA_IDX 4'h6
`define RTP_SR_CMD_WEL 8'h02
`define RTP_SR_CMD_REGISTER_WRITE_LATCH 8'h06
`define RTP_SR_CMD_CLR 8'h00
`define RTP_SR_WEL 1
`define RTP_SR_REGISTER_WRITE_LATCH 2
`define RTP_SR_AL0 5
`define RTP_SR_AL1 6
`define RTP_SR_BAT 7
`define RTP_INT_IM 7
`define RTP_INT_ALARM_ONE_ENABLE 6
`define RTP_INT_ALARM_ZERO_ENABLE 5
`define RTP_INT_FO_LO 3
`define RTP_PWR_BUS_OFF_IN_BACKUP 7
`define RTP_PWR_BSW 6
`define RTP_VTS_MAX 3'h4
`define RTP_VTS_DEF 3'h0
`define RTP_ATR_RST 8'h00
`define RTP_DTR_RST 8'h00
`define RTP_INT_RST 8'h00
`define RTP_LOAD_BASE_QPF 7'h12
`define RTP_DIV_4K 2
`define RTP_DIV_1HZ 14
`endif

// ==== rtl/rtp_pkg.sv ====
// Types of the trim, power and alarm control block.
// Assumes the constants header is included by the design file.
package rtp_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_dev = 3'b001,
    st_ahi = 3'b010,
    st_alo = 3'b011,
    st_wr = 3'b100,
    st_rd = 3'b101
  } rtp_state_e;
endpackage : rtp_pkg

// ==== rtl/rtp_ctrl.sv ====
// Serial-bus slave with trim, power control, unlock latches and alarms.
// Assumes scl/sda, supply and comparator pins are asynchronous and
// that time_i comes from timekeeping logic on ref_clk_i.
`timescale 1ns/1ps
`include "rtp_defs.svh"
module rtp_ctrl
  import rtp_pkg::*;
#(
  parameter int NV_CYCLES = `RTP_NV_CYC,
  parameter logic POLICY_DEFAULT = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic tb_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic battery_mode_i,
  input wire logic [4:0] vdd_below_i,
  input wire logic [47:0] time_i,
  output logic alarm_or_clock_pin_o,
  output logic alarm_or_clock_pin_oe_o,
  output logic supervisor_reset_n_o,
  output logic [5:0] cap_code_o,
  output logic [6:0] load_qpf_o,
  output logic rate_add_o,
  output logic rate_sub_o,
  output logic [1:0] rate_mag_o,
  output logic supply_switch_policy_o,
  output logic [2:0] reset_threshold_sel_o,
  output logic nv_busy_o
);
  localparam logic [11:0] PULSE_CYC = 12'(`RTP_PULSE_CYC);

  // Timebase divider; only its settled bits cross, never a count
  logic [14:0] tb_cnt_ff;
  logic [14:0] nxt_tb_cnt;
  always_comb begin
    nxt_tb_cnt = tb_cnt_ff + 15'h0001;
  end
  always_ff @(posedge tb_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tb_cnt_ff <= 15'h0000;
    end else begin
      tb_cnt_ff <= nxt_tb_cnt;
    end
  end

  // Two-flop synchronisers for every asynchronous level
  logic [10:0] sync1_ff;
  logic [10:0] sync2_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_ff <= 11'h003;
      sync2_ff <= 11'h003;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      sync1_ff <= {tb_clk_i, tb_cnt_ff[`RTP_DIV_4K], tb_cnt_ff[`RTP_DIV_1HZ],
                   battery_mode_i, vdd_below_i, scl_i, sda_i};
      sync2_ff <= sync1_ff;
      scl_d_ff <= sync2_ff[1];
      sda_d_ff <= sync2_ff[0];
    end
  end

  logic scl_s;
  logic sda_s;
  logic batt_s;
  logic [4:0] below_s;
  logic [2:0] fclk_s;
  assign sda_s = sync2_ff[0];
  assign scl_s = sync2_ff[1];
  assign below_s = sync2_ff[6:2];
  assign batt_s = sync2_ff[7];
  assign fclk_s = sync2_ff[10:8];

  // Bus conditions seen on the synchronised lines
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign bus_stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // Serial slave, latches and configuration registers
  rtp_state_e st_ff, nxt_st;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] tx_ff, nxt_tx;
  logic [7:0] addr_ff, nxt_addr;
  logic hi_ok_ff, nxt_hi_ok;
  logic oe_ff, nxt_oe;
  logic wel_ff, nxt_wel;
  logic register_write_latch_ff, nxt_register_write_latch;
  logic wrote_ff, nxt_wrote;
  logic [20:0] nv_cnt_ff, nxt_nv_cnt;
  logic busy_ff, nxt_busy;
  logic clr_ff, nxt_clr;
  logic [7:0] int_ff, nxt_int;
  logic [7:0] atr_ff, nxt_atr;
  logic [7:0] dtr_ff, nxt_dtr;
  logic [7:0] pwr_ff, nxt_pwr;
  logic [7:0] alarm_mem_ff [0:15];
  logic [7:0] nxt_alarm [0:15];
  logic al0_ff;
  logic al1_ff;
  logic bus_ok;
  logic defined;

  // Read data for the byte at one control-space offset
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      `RTP_OFF_SR: begin
        d[`RTP_SR_BAT] = batt_s;
        d[`RTP_SR_AL1] = al1_ff;
        d[`RTP_SR_AL0] = al0_ff;
        d[`RTP_SR_REGISTER_WRITE_LATCH] = register_write_latch_ff;
        d[`RTP_SR_WEL] = wel_ff;
      end
      `RTP_OFF_INT: d = int_ff;
      `RTP_OFF_ATR: d = atr_ff;
      `RTP_OFF_DTR: d = dtr_ff;
      `RTP_OFF_PWR: d = pwr_ff;
      default: begin
        if (a <= `RTP_OFF_ALM_TOP) begin
          d = alarm_mem_ff[a[3:0]];
        end
      end
    endcase
    return d;
  endfunction : rd_byte

  always_comb begin
    nxt_st = st_ff;
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    nxt_tx = tx_ff;
    nxt_addr = addr_ff;
    nxt_hi_ok = hi_ok_ff;
    nxt_oe = oe_ff;
    nxt_wel = wel_ff;
    nxt_register_write_latch = register_write_latch_ff;
    nxt_wrote = wrote_ff;
    nxt_clr = 1'b0;
    nxt_int = int_ff;
    nxt_atr = atr_ff;
    nxt_dtr = dtr_ff;
    nxt_pwr = pwr_ff;
    nxt_alarm = alarm_mem_ff;
    nxt_nv_cnt = (nv_cnt_ff != 21'h000000) ? nv_cnt_ff - 21'h000001 : nv_cnt_ff;
    defined = (addr_ff <= `RTP_OFF_ALM_TOP) ||
              (addr_ff >= `RTP_OFF_INT && addr_ff <= `RTP_OFF_PWR);
    // backup with bus off keeps the slave deaf
    bus_ok = ~(batt_s & pwr_ff[`RTP_PWR_BUS_OFF_IN_BACKUP]);
    if (!bus_ok) begin
      nxt_st = st_idle;
      nxt_bit = 4'h0;
      nxt_oe = 1'b0;
    end else if (bus_start) begin
      // a restart drops the write but keeps the latch
      nxt_st = st_dev;
      nxt_bit = 4'h0;
      nxt_oe = 1'b0;
      nxt_wrote = 1'b0;
    end else if (bus_stop) begin
      nxt_st = st_idle;
      nxt_oe = 1'b0;
      nxt_wrote = 1'b0;
      if (wrote_ff) begin
        // finished write relocks the register latch
        nxt_register_write_latch = 1'b0;
        // programming cycle holds off the bus
        nxt_nv_cnt = 21'(NV_CYCLES);
      end
    end else if (scl_rise && st_ff != st_idle) begin
      if (st_ff == st_rd) begin
        if (bit_ff == 4'h8) begin
          if (sda_s) begin
            nxt_st = st_idle;
          end else begin
            nxt_bit = 4'h0;
            nxt_addr = addr_ff + 8'h01;
            nxt_tx = rd_byte(addr_ff + 8'h01);
          end
        end else if (bit_ff < 4'h8) begin
          // The acknowledge clock of the address byte leaves the count at 9
          nxt_bit = bit_ff + 4'h1;
        end
      end else if (bit_ff < 4'h8) begin
        nxt_shift = {shift_ff[6:0], sda_s};
        nxt_bit = bit_ff + 4'h1;
      end
    end else if (scl_fall && st_ff != st_idle) begin
      if (bit_ff == 4'h9) begin
        nxt_bit = 4'h0;
        nxt_oe = (st_ff == st_rd) ? ~tx_ff[7] : 1'b0;
      end else if (st_ff == st_rd) begin
        if (bit_ff == 4'h8) begin
          nxt_oe = 1'b0;
          // status read clears the alarm flags here
          nxt_clr = (addr_ff == `RTP_OFF_SR);
        end else begin
          nxt_oe = ~tx_ff[3'(4'h7 - bit_ff)];
        end
      end else if (bit_ff == 4'h8) begin
        nxt_bit = 4'h9;
        nxt_oe = 1'b1;
        case (st_ff)
          st_dev: begin
            if (shift_ff[7:1] == `RTP_DEV_ADDR && nv_cnt_ff == 21'h000000) begin
              nxt_st = shift_ff[0] ? st_rd : st_ahi;
              nxt_tx = rd_byte(addr_ff);
            end else begin
              nxt_st = st_idle;
              nxt_oe = 1'b0;
              nxt_bit = 4'h0;
            end
          end
          st_ahi: begin
            nxt_hi_ok = (shift_ff == 8'h00);
            nxt_st = st_alo;
          end
          st_alo: begin
            nxt_addr = shift_ff;
            nxt_st = st_wr;
          end
          st_wr: begin
            nxt_addr = addr_ff + 8'h01;
            if (hi_ok_ff && addr_ff == `RTP_OFF_SR) begin
              if (shift_ff == `RTP_SR_CMD_WEL) begin
                nxt_wel = 1'b1;
              end else if (shift_ff == `RTP_SR_CMD_REGISTER_WRITE_LATCH && wel_ff) begin
                nxt_register_write_latch = 1'b1;
                nxt_wel = 1'b1;
              end else if (shift_ff == `RTP_SR_CMD_CLR) begin
                nxt_wel = 1'b0;
                nxt_register_write_latch = 1'b0;
              end
            end else if (hi_ok_ff && wel_ff && register_write_latch_ff && defined) begin
              nxt_wrote = 1'b1;
              case (addr_ff)
                `RTP_OFF_INT: nxt_int = {shift_ff[7:3], 3'h0};
                // six trim bits, top bits read zero
                `RTP_OFF_ATR: nxt_atr = {2'h0, shift_ff[5:0]};
                `RTP_OFF_DTR: nxt_dtr = {5'h00, shift_ff[2:0]};
                // threshold field writable only under the full unlock
                `RTP_OFF_PWR: nxt_pwr = {shift_ff[7:6], 3'h0, shift_ff[2:0]};
                default: nxt_alarm[addr_ff[3:0]] = shift_ff;
              endcase
            end
          end
          default: nxt_st = st_idle;
        endcase
      end
    end
    // Busy taken from the next count so the flop tracks the counter
    nxt_busy = (nxt_nv_cnt != 21'h000000);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= st_idle;
      bit_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      addr_ff <= 8'h00;
      hi_ok_ff <= 1'b0;
      oe_ff <= 1'b0;
      wel_ff <= 1'b0;
      register_write_latch_ff <= 1'b0;
      wrote_ff <= 1'b0;
      nv_cnt_ff <= 21'h000000;
      busy_ff <= 1'b0;
      clr_ff <= 1'b0;
      int_ff <= `RTP_INT_RST;
      atr_ff <= `RTP_ATR_RST;
      dtr_ff <= `RTP_DTR_RST;
      // variant sets the switch policy default
      pwr_ff <= {1'b0, POLICY_DEFAULT, 3'h0, `RTP_VTS_DEF};
      for (int i = 0; i < 16; i++) begin
        alarm_mem_ff[i] <= 8'h00;
      end
    end else begin
      st_ff <= nxt_st;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      tx_ff <= nxt_tx;
      addr_ff <= nxt_addr;
      hi_ok_ff <= nxt_hi_ok;
      oe_ff <= nxt_oe;
      wel_ff <= nxt_wel;
      register_write_latch_ff <= nxt_register_write_latch;
      wrote_ff <= nxt_wrote;
      nv_cnt_ff <= nxt_nv_cnt;
      busy_ff <= nxt_busy;
      clr_ff <= nxt_clr;
      int_ff <= nxt_int;
      atr_ff <= nxt_atr;
      dtr_ff <= nxt_dtr;
      pwr_ff <= nxt_pwr;
      alarm_mem_ff <= nxt_alarm;
    end
  end

  // enabled fields only, day of week sits at offset 6
  function automatic logic alarm_hit(input logic [3:0] base);
    logic hit_any;
    logic hit_all;
    logic [3:0] idx;
    hit_any = 1'b0;
    hit_all = 1'b1;
    for (int k = 0; k < 6; k++) begin
      idx = base + ((k == 5) ? `RTP_DWA_IDX : 4'(k));
      if (alarm_mem_ff[idx][7]) begin
        hit_any = 1'b1;
        if (alarm_mem_ff[idx][6:0] != time_i[k*8 +: 7]) begin
          hit_all = 1'b0;
        end
      end
    end
    return hit_any & hit_all;
  endfunction : alarm_hit

  // Alarm flags and the shared alarm or clock pin
  logic hit0;
  logic hit1;
  logic ev0;
  logic ev1;
  logic pulsed;
  logic [1:0] fo_sel;
  logic hit0_ff, hit1_ff;
  logic nxt_al0, nxt_al1;
  logic [11:0] pcnt_ff, nxt_pcnt;
  logic pin_oe_ff, nxt_pin_oe;
  always_comb begin
    hit0 = alarm_hit(4'h0);
    hit1 = alarm_hit(`RTP_OFF_ALM1);
    ev0 = hit0 & ~hit0_ff;
    ev1 = hit1 & ~hit1_ff;
    fo_sel = int_ff[`RTP_INT_FO_LO +: 2];
    pulsed = int_ff[`RTP_INT_IM] && fo_sel == 2'h0;
    // set on match start, set beats a read clear
    nxt_al0 = ev0 | (al0_ff & ~clr_ff);
    nxt_al1 = ev1 | (al1_ff & ~clr_ff);
    // the pulse ends when its count runs out or pulsed mode is left
    nxt_pcnt = 12'h000;
    if (pulsed) begin
      if ((ev0 & int_ff[`RTP_INT_ALARM_ZERO_ENABLE]) | (ev1 & int_ff[`RTP_INT_ALARM_ONE_ENABLE])) begin
        // every enabled match restarts a pulse
        // width of about one timebase period
        nxt_pcnt = PULSE_CYC;
      end else if (pcnt_ff != 12'h000) begin
        nxt_pcnt = pcnt_ff - 12'h001;
      end
    end
    case (fo_sel)
      // clock outputs take the pin from the alarms
      2'h1: nxt_pin_oe = ~fclk_s[2];
      2'h2: nxt_pin_oe = ~fclk_s[1];
      2'h3: nxt_pin_oe = ~fclk_s[0];
      default: begin
        if (int_ff[`RTP_INT_IM]) begin
          nxt_pin_oe = (pcnt_ff != 12'h000);
        end else begin
          // pin stays low while an enabled flag is unread
          nxt_pin_oe = (al0_ff & int_ff[`RTP_INT_ALARM_ZERO_ENABLE]) | (al1_ff & int_ff[`RTP_INT_ALARM_ONE_ENABLE]);
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hit0_ff <= 1'b0;
      hit1_ff <= 1'b0;
      al0_ff <= 1'b0;
      al1_ff <= 1'b0;
      pcnt_ff <= 12'h000;
      pin_oe_ff <= 1'b0;
    end else begin
      hit0_ff <= hit0;
      hit1_ff <= hit1;
      al0_ff <= nxt_al0;
      al1_ff <= nxt_al1;
      pcnt_ff <= nxt_pcnt;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  // Supervisor reset and registered trim outputs
  logic [2:0] vts_eff;
  logic sel_low;
  logic hold_ff, nxt_hold;
  logic rst_n_ff, nxt_rst_n;
  logic [6:0] load_ff, nxt_load;
  logic add_ff, nxt_add;
  logic sub_ff, nxt_sub;
  logic [1:0] mag_ff, nxt_mag;
  always_comb begin
    // undefined codes fall back to the highest level
    vts_eff = (pwr_ff[2:0] > `RTP_VTS_MAX) ? `RTP_VTS_DEF : pwr_ff[2:0];
    // selected comparator, code 0 is the highest level
    sel_low = below_s[vts_eff];
    // in backup a dip latches reset until main returns
    nxt_hold = batt_s & (hold_ff | sel_low);
    nxt_rst_n = ~(sel_low | hold_ff);
    // quarter-pF load, bit5 counts when clear
    nxt_load = `RTP_LOAD_BASE_QPF + {~atr_ff[5], atr_ff[4:0]};
    // ten and twenty ppm weights, zero means none
    nxt_mag = {dtr_ff[0], dtr_ff[1]};
    // sign picks adding or removing counts
    nxt_add = ~dtr_ff[2] & (nxt_mag != 2'h0);
    nxt_sub = dtr_ff[2] & (nxt_mag != 2'h0);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_ff <= 1'b0;
      rst_n_ff <= 1'b0;
      load_ff <= 7'h00;
      add_ff <= 1'b0;
      sub_ff <= 1'b0;
      mag_ff <= 2'h0;
    end else begin
      hold_ff <= nxt_hold;
      rst_n_ff <= nxt_rst_n;
      load_ff <= nxt_load;
      add_ff <= nxt_add;
      sub_ff <= nxt_sub;
      mag_ff <= nxt_mag;
    end
  end

  // Open-drain pins only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_ff;
  assign alarm_or_clock_pin_o = 1'b0;
  assign alarm_or_clock_pin_oe_o = pin_oe_ff;
  assign supervisor_reset_n_o = rst_n_ff;
  assign cap_code_o = atr_ff[5:0];
  assign load_qpf_o = load_ff;
  assign rate_add_o = add_ff;
  assign rate_sub_o = sub_ff;
  assign rate_mag_o = mag_ff;
  assign supply_switch_policy_o = pwr_ff[`RTP_PWR_BSW];
  assign reset_threshold_sel_o = pwr_ff[2:0];
  assign nv_busy_o = busy_ff;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_register_write_latch_needs_wel: assert property ($rose(register_write_latch_ff) |-> $past(wel_ff) && wel_ff)
    else $error("register latch set without write enable");
  a_wel_step_one: assert property ($rose(wel_ff) |-> $past(st_ff) == st_wr && $past(shift_ff) == 8'h02)
    else $error("write enable set by wrong byte");
  a_register_write_latch_stop_clear: assert property (bus_ok && bus_stop && wrote_ff |=> !register_write_latch_ff && nv_busy_o)
    else $error("register latch kept after completed write");
  a_register_write_latch_kept_abort: assert property (bus_ok && bus_start && register_write_latch_ff |=> register_write_latch_ff)
    else $error("register latch lost on restart");
  a_flag_on_match: assert property (ev0 |=> al0_ff)
    else $error("alarm 0 flag not set on match");
  a_flag_read_clear: assert property (clr_ff && !ev1 |=> !al1_ff)
    else $error("alarm 1 flag survived status read");
  a_single_hold: assert property (fo_sel == 2'h0 && !int_ff[`RTP_INT_IM] && al0_ff && int_ff[`RTP_INT_ALARM_ZERO_ENABLE]
                                  |=> alarm_or_clock_pin_oe_o)
    else $error("single event pin released before read");
  a_pulse_start: assert property (pulsed && ev1 && int_ff[`RTP_INT_ALARM_ONE_ENABLE] |=> pcnt_ff == PULSE_CYC ##1 alarm_or_clock_pin_oe_o)
    else $error("pulsed mode missed a match");
  a_bus_off_quiet: assert property (!bus_ok |=> !sda_oe_o)
    else $error("bus answered while off in backup");
  a_reset_held: assert property (hold_ff |=> !supervisor_reset_n_o)
    else $error("backup reset released early");
  a_rate_zero: assert property (rate_mag_o == 2'h0 |-> !rate_add_o && !rate_sub_o)
    else $error("correction applied with zero magnitude");
endmodule : rtp_ctrl

// ==== tb/rtp_host.sv ====
// Host bus master model for the trim, power and alarm block.
// Assumes the bench resolves SDA as open drain with a pull-up.
`timescale 1ns/1ps
`include "rtp_defs.svh"
module rtp_host (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  logic ok;
  // Bus idles released
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    ok = 1'b1;
  end
  // Six cycles a quarter bit leaves room for the slave's input sync
  task automatic q();
    repeat (6) @(negedge ref_clk_i);
  endtask : q
  // Data changes only while SCL is low
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = !b;
    q();
    scl_o = 1'b1;
    q();
    r = sda_i;
    q();
    scl_o = 1'b0;
    q();
  endtask : bit_io
  // Serves as start and as repeated start
  task automatic start();
    sda_low_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b0;
    q();
  endtask : start
  task automatic stop();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_low_o = 1'b0;
    q();
  endtask : stop
  // Ninth bit released; a missing ack on a write clears ok
  task automatic xfer(input logic [7:0] b, input logic rd, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
    bit_io(1'b1, a);
    if (!rd && a) begin
      ok = 1'b0;
    end
  endtask : xfer
  // slave byte, address, one data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic stp);
    logic [7:0] x;
    ok = 1'b1;
    start();
    xfer({`RTP_DEV_ADDR, 1'b0}, 1'b0, x);
    xfer(8'h00, 1'b0, x);
    xfer(a, 1'b0, x);
    xfer(d, 1'b0, x);
    if (stp) begin
      stop();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] x;
    ok = 1'b1;
    start();
    xfer({`RTP_DEV_ADDR, 1'b0}, 1'b0, x);
    xfer(8'h00, 1'b0, x);
    xfer(a, 1'b0, x);
    start();
    xfer({`RTP_DEV_ADDR, 1'b1}, 1'b0, x);
    xfer(8'hff, 1'b1, d);
    stop();
  endtask : rd
  // two unlock steps, each its own transaction
  task automatic unlock();
    wr(`RTP_OFF_SR, `RTP_SR_CMD_WEL, 1'b1);
    wr(`RTP_OFF_SR, `RTP_SR_CMD_REGISTER_WRITE_LATCH, 1'b1);
  endtask : unlock
endmodule : rtp_host

// ==== tb/testbench.sv ====
// Self-checking bench for the trim, power and alarm block.
// Assumes the host model drives the serial pins; NV_CYCLES shortened.
`timescale 1ns/1ps
`include "rtp_defs.svh"
module testbench;
  logic ref_clk = 1'b0;
  logic tb_clk = 1'b0;
  logic resetn = 1'b0;
  logic batt = 1'b0;
  logic [4:0] below = 5'h00;
  logic [47:0] tm = 48'h0;
  logic scl, sda_low, sda_oe, pin_oe, rst_n, r_add, r_sub, pol, busy, sda_v, pin_v;
  logic [5:0] cap;
  logic [6:0] load;
  logic [1:0] mag;
  logic [2:0] thr;
  logic [7:0] d;
  int n_mismatch = 0;
  int checks = 0;
  // Open-drain data line with pull-up
  wire sda = !(sda_low | sda_oe);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Timebase skewed in phase against the register clock
  initial begin
    #3;
    forever #80 tb_clk = ~tb_clk;
  end
  rtp_ctrl #(.NV_CYCLES(50)) u_rtp_ctrl (.ref_clk_i(ref_clk), .resetn_i(resetn), .tb_clk_i(tb_clk),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_v), .sda_oe_o(sda_oe), .battery_mode_i(batt), .vdd_below_i(below),
    .time_i(tm), .alarm_or_clock_pin_o(pin_v), .alarm_or_clock_pin_oe_o(pin_oe), .supervisor_reset_n_o(rst_n),
    .cap_code_o(cap), .load_qpf_o(load), .rate_add_o(r_add), .rate_sub_o(r_sub), .rate_mag_o(mag),
    .supply_switch_policy_o(pol), .reset_threshold_sel_o(thr), .nv_busy_o(busy));
  rtp_host u_rtp_host (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t value mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle
  task automatic rd(input logic [7:0] a);
    u_rtp_host.rd(a, d);
  endtask : rd
  // Full unlock, one write, then wait out the programming cycle
  task automatic cw(input logic [7:0] a, input logic [7:0] v);
    u_rtp_host.unlock();
    u_rtp_host.wr(a, v, 1'b1);
    idle(60);
  endtask : cw
  task automatic edges(output int e);
    logic p;
    e = 0;
    p = pin_oe;
    repeat (600) begin
      @(negedge ref_clk);
      if (pin_oe !== p) e++;
      p = pin_oe;
    end
  endtask : edges
  task automatic t_reset();
    chk(load, 8'h32);
    chk(cap, 8'h00);
    chk({sda_v, pin_v}, 8'h00);
    chk({r_add, r_sub, mag, pol}, 8'h00);
    rd(`RTP_OFF_PWR);
    chk(d, 8'h00);
  endtask : t_reset
  task automatic t_unlock();
    u_rtp_host.wr(`RTP_OFF_SR, `RTP_SR_CMD_WEL, 1'b1);
    rd(`RTP_OFF_SR);
    chk(d & 8'h06, 8'h02);
    u_rtp_host.wr(`RTP_OFF_SR, `RTP_SR_CMD_REGISTER_WRITE_LATCH, 1'b1);
    rd(`RTP_OFF_SR);
    chk(d & 8'h06, 8'h06);
    u_rtp_host.wr(`RTP_OFF_ATR, 8'h20, 1'b1);
    idle(2);
    chk({busy, load}, 8'h92);
    idle(60);
    chk(busy, 8'h00);
    rd(`RTP_OFF_SR);
    chk(d & 8'h04, 8'h00);
    cw(`RTP_OFF_ATR, 8'h1f);
    chk(load, 8'h51);
  endtask : t_unlock
  task automatic t_rate();
    logic [1:0] m;
    for (int i = 0; i < 8; i++) begin
      cw(`RTP_OFF_DTR, 8'(i));
      m = {i[0], i[1]};
      chk({r_add, r_sub, mag}, {4'h0, !i[2] && m != 2'h0, i[2] && m != 2'h0, m});
    end
  endtask : t_rate
  task automatic t_lock();
    u_rtp_host.wr(`RTP_OFF_DTR, 8'h00, 1'b1);
    idle(2);
    chk({r_sub, mag}, 8'h07);
    u_rtp_host.unlock();
    u_rtp_host.wr(`RTP_OFF_SR, `RTP_SR_CMD_CLR, 1'b1);
    rd(`RTP_OFF_SR);
    chk(d & 8'h06, 8'h00);
    u_rtp_host.unlock();
    u_rtp_host.wr(`RTP_OFF_DTR, 8'h05, 1'b0);
    rd(`RTP_OFF_SR);
    chk({busy, d[2]}, 8'h01);
    u_rtp_host.wr(8'h15, 8'hff, 1'b1);
    idle(2);
    chk({busy, r_add, r_sub, mag}, 8'h06);
    u_rtp_host.wr(`RTP_OFF_SR, `RTP_SR_CMD_CLR, 1'b1);
  endtask : t_lock
  task automatic t_power();
    cw(`RTP_OFF_PWR, 8'h42);
    below = 5'h08;
    idle(10);
    chk({pol, thr, rst_n}, 8'h15);
    batt = 1'b1;
    below = 5'h04;
    idle(10);
    chk(rst_n, 8'h00);
    below = 5'h00;
    idle(10);
    chk(rst_n, 8'h00);
    batt = 1'b0;
    idle(10);
    chk(rst_n, 8'h01);
    cw(`RTP_OFF_PWR, 8'h85);
    below = 5'h01;
    idle(10);
    chk(rst_n, 8'h00);
    below = 5'h00;
    batt = 1'b1;
    idle(10);
    rd(`RTP_OFF_PWR);
    chk(u_rtp_host.ok, 8'h00);
    batt = 1'b0;
    idle(10);
    rd(`RTP_OFF_PWR);
    chk(d, 8'h85);
  endtask : t_power
  task automatic t_alarm();
    cw(8'h00, 8'h85);
    // Second alarm on the same seconds value so both flags move together
    cw(8'h08, 8'h85);
    tm = 48'h3305;
    idle(6);
    chk(pin_oe, 8'h00);
    rd(`RTP_OFF_SR);
    chk(d[6:5], 8'h03);
    tm = 48'h0;
    cw(`RTP_OFF_INT, 8'h20);
    for (int k = 0; k < 2; k++) begin
      tm = 48'h0005;
      idle(6);
      tm = 48'h0;
      chk(pin_oe, 8'h01);
    end
    rd(`RTP_OFF_SR);
    idle(10);
    chk({pin_oe, d[5]}, 8'h01);
    rd(`RTP_OFF_SR);
    chk(d[6:5], 8'h00);
    cw(`RTP_OFF_INT, 8'he0);
    for (int k = 0; k < 2; k++) begin
      tm = 48'h0005;
      idle(3040);
      chk(pin_oe, 8'h01);
      tm = 48'h0;
      idle(20);
      chk(pin_oe, 8'h00);
    end
  endtask : t_alarm
  task automatic t_fout();
    int e;
    cw(`RTP_OFF_INT, 8'h08);
    edges(e);
    chk(e inside {[73:77]}, 8'h01);
    cw(`RTP_OFF_INT, 8'h10);
    edges(e);
    chk(e inside {[8:10]}, 8'h01);
    // Flags cleared first, so a pin still obeying the alarms would move
    rd(`RTP_OFF_SR);
    cw(`RTP_OFF_INT, 8'h38);
    tm = 48'h0005;
    edges(e);
    chk(e == 0, 8'h01);
    chk(pin_oe, 8'h01);
  endtask : t_fout
  // Main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    idle(10);
    t_reset();
    t_unlock();
    t_rate();
    t_lock();
    t_power();
    t_alarm();
    t_fout();
    summarize();
  end
  // Watchdog beyond the expected run of about 83k cycles
  initial begin
    repeat (96000) @(negedge ref_clk);
    n_mismatch++;
    summarize();
  end
endmodule : testbench
